/* hdl/dlm_top.sv */
// descriptor list map bank: done, skip and final-descriptor maps for
// the periodic poll list and the async_list, with their scanners
// assumes classic wishbone master, synchronous active-high reset
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module dlm_top (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone classic slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [31:0]       adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  // periodic poll list, facing the host core
  input  wire logic [15:0]       per_valid_i,
  input  wire logic              per_exec_done_i,
  output dlm_pkg::dlm_req_s      per_req_o,
  // async_list, facing the host core
  input  wire logic [15:0]       asy_valid_i,
  input  wire logic              asy_exec_done_i,
  output dlm_pkg::dlm_req_s      asy_req_o
);
  import dlm_pkg::*;

  // ==========================================================
  // register state
  logic [15:0]   periodic_done_bits;
  logic [15:0]   periodic_skip_mask;
  logic [15:0]   periodic_last_marker;
  logic [15:0]   async_done_bits;
  logic [15:0]   async_skip_mask;
  logic [15:0]   async_last_marker;

  logic [15:0]   next_periodic_done_bits;
  logic [15:0]   next_periodic_skip_mask;
  logic [15:0]   next_periodic_last_marker;
  logic [15:0]   next_async_done_bits;
  logic [15:0]   next_async_skip_mask;
  logic [15:0]   next_async_last_marker;

  logic [31:0]   next_dat;
  logic          next_ack;

  dlm_fin_s      per_fin;
  dlm_fin_s      asy_fin;

  logic          acc;
  logic          wr;
  logic          rd;
  logic [7:0]    ix;
  logic [15:0]   per_set;
  logic [15:0]   asy_set;
  logic [15:0]   per_clr;
  logic [15:0]   asy_clr;

  // ==========================================================
  // helpers
  function automatic logic [7:0] word_index(input logic [31:0] a);
    return a[9:2];
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic [15:0] onehot(input dlm_fin_s f);
    logic [15:0] r;
    r = '0;
    if (f.vld) begin
      r[f.idx] = 1'b1;
    end
    return r;
  endfunction

  // ==========================================================
  // scanners
  dlm_sched u_per_sched (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .valid_i     (per_valid_i),
    .skip_i      (periodic_skip_mask),
    .last_i      (periodic_last_marker),
    .exec_done_i (per_exec_done_i),
    .req_o       (per_req_o),
    .fin_o       (per_fin)
  );

  dlm_sched u_asy_sched (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .valid_i     (asy_valid_i),
    .skip_i      (async_skip_mask),
    .last_i      (async_last_marker),
    .exec_done_i (asy_exec_done_i),
    .req_o       (asy_req_o),
    .fin_o       (asy_fin)
  );

  // ==========================================================
  // bus decode
  // one wait state; the access commits on the edge that raises ack
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr  = acc && we_i;
  assign rd  = acc && !we_i;
  assign ix  = word_index(adr_i);

  always_comb begin
    next_ack = acc;
    next_dat = dat_o;
    if (rd) begin
      next_dat = 32'h0000_0000;
      case (ix)
        DLM_IX_PER_DONE: next_dat[15:0] = periodic_done_bits;
        DLM_IX_PER_SKIP: next_dat[15:0] = periodic_skip_mask;
        DLM_IX_PER_LAST: next_dat[15:0] = periodic_last_marker;
        DLM_IX_ASY_DONE: next_dat[15:0] = async_done_bits;
        DLM_IX_ASY_SKIP: next_dat[15:0] = async_skip_mask;
        DLM_IX_ASY_LAST: next_dat[15:0] = async_last_marker;
        default:         next_dat = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // done maps
  // set wins over read-clear so a completion racing the read survives
  always_comb begin
    per_set = onehot(per_fin);
    asy_set = onehot(asy_fin);
    per_clr = (rd && ix == DLM_IX_PER_DONE) ? periodic_done_bits : '0;
    asy_clr = (rd && ix == DLM_IX_ASY_DONE) ? async_done_bits : '0;
    // writes are ignored: the maps are read-only
    next_periodic_done_bits =
      (periodic_done_bits & ~per_clr) | per_set;
    next_async_done_bits =
      (async_done_bits & ~asy_clr) | asy_set;
  end

  // ==========================================================
  // skip masks and final markers
  always_comb begin
    next_periodic_skip_mask   = periodic_skip_mask;
    next_periodic_last_marker = periodic_last_marker;
    next_async_skip_mask      = async_skip_mask;
    next_async_last_marker    = async_last_marker;
    if (wr) begin
      case (ix)
        DLM_IX_PER_SKIP: next_periodic_skip_mask =
          merge(periodic_skip_mask, dat_i, sel_i);
        DLM_IX_PER_LAST: next_periodic_last_marker =
          merge(periodic_last_marker, dat_i, sel_i);
        DLM_IX_ASY_SKIP: next_async_skip_mask =
          merge(async_skip_mask, dat_i, sel_i);
        DLM_IX_ASY_LAST: next_async_last_marker =
          merge(async_last_marker, dat_i, sel_i);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periodic_done_bits   <= DLM_RST_DONE;
      async_done_bits      <= DLM_RST_DONE;
      periodic_skip_mask   <= DLM_RST_SKIP;
      async_skip_mask      <= DLM_RST_SKIP;
      periodic_last_marker <= DLM_RST_LAST;
      async_last_marker    <= DLM_RST_LAST;
      dat_o                <= 32'h0000_0000;
      ack_o                <= 1'b0;
    end else begin
      periodic_done_bits   <= next_periodic_done_bits;
      async_done_bits      <= next_async_done_bits;
      periodic_skip_mask   <= next_periodic_skip_mask;
      async_skip_mask      <= next_async_skip_mask;
      periodic_last_marker <= next_periodic_last_marker;
      async_last_marker    <= next_async_last_marker;
      dat_o                <= next_dat;
      ack_o                <= next_ack;
    end
  end

  // ==========================================================
  // checks
  chk_per_done_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    per_fin.vld |=> periodic_done_bits[$past(per_fin.idx)])
    else $error("periodic completion not recorded");

  chk_asy_done_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asy_fin.vld |=> async_done_bits[$past(asy_fin.idx)])
    else $error("async completion not recorded");

  chk_read_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && ix == DLM_IX_PER_DONE && !per_fin.vld)
      |=> ack_o && (periodic_done_bits & dat_o[15:0]) == 16'h0000)
    else $error("done read did not clear returned bits");

  chk_asy_read_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && ix == DLM_IX_ASY_DONE && !asy_fin.vld)
      |=> ack_o && (async_done_bits & dat_o[15:0]) == 16'h0000)
    else $error("async done read did not clear returned bits");

  chk_read_returns: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && ix == DLM_IX_ASY_DONE) |=> dat_o[15:0] == $past(async_done_bits))
    else $error("done read returned wrong bits");

  chk_race_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && ix == DLM_IX_ASY_DONE && asy_fin.vld)
      |=> async_done_bits[$past(asy_fin.idx)])
    else $error("completion lost to read clear");

  chk_per_race_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && ix == DLM_IX_PER_DONE && per_fin.vld)
      |=> periodic_done_bits[$past(per_fin.idx)])
    else $error("periodic completion lost to read clear");

  chk_done_ro: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && ix == DLM_IX_PER_DONE && !per_fin.vld)
      |=> $stable(periodic_done_bits))
    else $error("done map changed by a write");

  chk_asy_done_ro: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && ix == DLM_IX_ASY_DONE && !asy_fin.vld)
      |=> $stable(async_done_bits))
    else $error("async done map changed by a write");

  chk_skip_reset: assert property (
    @(posedge clk_i)
    rst_i |=> periodic_skip_mask == DLM_RST_SKIP
      && async_skip_mask == DLM_RST_SKIP
      && periodic_done_bits == DLM_RST_DONE)
    else $error("reset values wrong");

  chk_last_reset: assert property (
    @(posedge clk_i)
    rst_i |=> periodic_last_marker == DLM_RST_LAST
      && async_last_marker == DLM_RST_LAST
      && async_done_bits == DLM_RST_DONE)
    else $error("marker reset values wrong");

  chk_last_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && ix == DLM_IX_ASY_LAST && sel_i[1:0] == 2'b11)
      |=> async_last_marker == $past(dat_i[15:0]))
    else $error("final marker write lost");

  chk_per_last_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && ix == DLM_IX_PER_LAST && sel_i[1:0] == 2'b11)
      |=> periodic_last_marker == $past(dat_i[15:0]))
    else $error("periodic final marker write lost");

  chk_skip_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && ix == DLM_IX_PER_SKIP && sel_i[1:0] == 2'b11)
      |=> ##1 periodic_skip_mask == $past(dat_i[15:0], 2))
    else $error("skip mask write lost");

  chk_asy_skip_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && ix == DLM_IX_ASY_SKIP && sel_i[1:0] == 2'b11)
      |=> async_skip_mask == $past(dat_i[15:0]))
    else $error("async skip mask write lost");

  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");

  chk_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged");

  cov_done_read: cover property (@(posedge clk_i) disable iff (rst_i)
    rd && ix == DLM_IX_PER_DONE && periodic_done_bits != 16'h0000);

  cov_race: cover property (@(posedge clk_i) disable iff (rst_i)
    rd && ix == DLM_IX_ASY_DONE && asy_fin.vld);

  cov_issue: cover property (@(posedge clk_i) disable iff (rst_i)
    per_req_o.start ##[1:20] per_fin.vld);

  cov_asy_issue: cover property (@(posedge clk_i) disable iff (rst_i)
    asy_req_o.start ##[1:20] asy_fin.vld);

endmodule

/* hdl/dlm_pkg.sv */
// shared constants and carriers for the descriptor list map bank
// assumes one 10 MHz clock and a classic wishbone slave port
package dlm_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned DLM_DESC_N  = 16;
  localparam int unsigned DLM_IDX_W   = 4;
  localparam int unsigned DLM_REG_W   = 16;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] DLM_IX_PER_DONE  = 8'hAA;
  localparam logic [7:0] DLM_IX_PER_SKIP  = 8'hAC;
  localparam logic [7:0] DLM_IX_PER_LAST  = 8'hAF;
  localparam logic [7:0] DLM_IX_ASY_DONE  = 8'hB0;
  localparam logic [7:0] DLM_IX_ASY_SKIP  = 8'hB2;
  localparam logic [7:0] DLM_IX_ASY_LAST  = 8'hB4;

  // ==========================================================
  // reset values
  localparam logic [15:0] DLM_RST_DONE = 16'h0000;
  localparam logic [15:0] DLM_RST_SKIP = 16'hFFFF;
  localparam logic [15:0] DLM_RST_LAST = 16'h0000;

  // ==========================================================
  // timing
  localparam int unsigned DLM_CLK_HZ       = 10_000_000;
  localparam int unsigned DLM_SKIP_RB_NS   = 100;
  localparam int unsigned DLM_SKIP_RB_CYC  =
    ((DLM_SKIP_RB_NS * (DLM_CLK_HZ / 1_000_000)) + 999) / 1000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic                 start;
    logic [3:0]           idx;
  } dlm_req_s;

  typedef struct packed {
    logic                 vld;
    logic [3:0]           idx;
  } dlm_fin_s;

  typedef enum logic {
    DLM_ST_SCAN,
    DLM_ST_WAIT
  } dlm_state_e;

endpackage

/* hdl/dlm_sched.sv */
// per-list descriptor scanner: walks descriptors, honours skip and
// final_descriptor_marker bits, reports completions
// assumes the host core pulses exec_done_i once per issued descriptor
`timescale 1ns/1ps
module dlm_sched (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [15:0]       valid_i,
  input  wire logic [15:0]       skip_i,
  input  wire logic [15:0]       last_i,
  input  wire logic              exec_done_i,
  output dlm_pkg::dlm_req_s      req_o,
  output dlm_pkg::dlm_fin_s      fin_o
);
  import dlm_pkg::*;

  dlm_state_e   state;
  dlm_state_e   next_state;
  logic [3:0]   idx;
  logic [3:0]   next_idx;
  dlm_req_s     next_req;
  dlm_fin_s     next_fin;

  // wrap after the marked descriptor or after the sixteenth
  function automatic logic [3:0] step(input logic [3:0] i,
                                      input logic [15:0] last);
    if (last[i] || i == 4'(DLM_DESC_N - 1)) begin
      return 4'h0;
    end
    return i + 4'h1;
  endfunction

  // ==========================================================
  // scan control
  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_req   = '0;
    next_fin   = '0;
    case (state)
      DLM_ST_SCAN: begin
        if (valid_i[idx] && !skip_i[idx]) begin
          next_req.start = 1'b1;
          next_req.idx   = idx;
          next_state     = DLM_ST_WAIT;
        end else begin
          next_idx = step(idx, last_i);
        end
      end
      DLM_ST_WAIT: begin
        // skip changes mid-run are not looked at here
        if (exec_done_i) begin
          next_fin.vld = 1'b1;
          next_fin.idx = idx;
          next_idx     = step(idx, last_i);
          next_state   = DLM_ST_SCAN;
        end
      end
      default: begin
        next_state = DLM_ST_SCAN;
        next_idx   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= DLM_ST_SCAN;
      idx   <= 4'h0;
      req_o <= '0;
      fin_o <= '0;
    end else begin
      state <= next_state;
      idx   <= next_idx;
      req_o <= next_req;
      fin_o <= next_fin;
    end
  end

  // ==========================================================
  // checks
  chk_skip_no_issue: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == DLM_ST_SCAN && skip_i[idx]) |=> !req_o.start)
    else $error("skipped descriptor was issued");

  chk_last_wraps: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == DLM_ST_WAIT && exec_done_i && last_i[idx])
      |=> (idx == 4'h0) && fin_o.vld)
    else $error("no wrap after final descriptor");

  chk_last_bounds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == DLM_ST_SCAN && !(valid_i[idx] && !skip_i[idx])
      && last_i[idx]) |=> idx == 4'h0)
    else $error("scan passed the final descriptor");

  cov_wrap_early: cover property (@(posedge clk_i) disable iff (rst_i)
    fin_o.vld && idx == 4'h0 && fin_o.idx != 4'hF);

endmodule

/* test/dlm_top_tb.sv */
// self-checking bench for the descriptor list map bank
// assumes dlm_pkg and dlm_top compiled first; drives the wishbone port
// and stands in for the host core on both scheduler links
`timescale 1ns/1ps
module dlm_top_tb;
  import dlm_pkg::*;

  // ==========================================================
  // stimulus and design
  logic        clk_i           = 1'b0;
  logic        rst_i           = 1'b1;
  logic        cyc_i           = 1'b0;
  logic        stb_i           = 1'b0;
  logic        we_i            = 1'b0;
  logic [31:0] adr_i           = 32'h0000_0000;
  logic [3:0]  sel_i           = 4'h0;
  logic [31:0] dat_i           = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [15:0] per_valid_i     = 16'h0000;
  logic        per_exec_done_i = 1'b0;
  dlm_req_s    per_req_o;
  logic [15:0] asy_valid_i     = 16'h0000;
  logic        asy_exec_done_i = 1'b0;
  dlm_req_s    asy_req_o;
  int          err_total       = 0;
  int          n_checks        = 0;
  int          per_iss         = 0;
  int          asy_iss         = 0;
  int          per_srv         = 0;
  int          asy_srv         = 0;
  logic [3:0]  per_iss_ix      = 4'h0;
  logic [3:0]  asy_iss_ix      = 4'h0;

  always #50 clk_i = ~clk_i;

  dlm_top dut (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .cyc_i           (cyc_i),
    .stb_i           (stb_i),
    .we_i            (we_i),
    .adr_i           (adr_i),
    .sel_i           (sel_i),
    .dat_i           (dat_i),
    .dat_o           (dat_o),
    .ack_o           (ack_o),
    .per_valid_i     (per_valid_i),
    .per_exec_done_i (per_exec_done_i),
    .per_req_o       (per_req_o),
    .asy_valid_i     (asy_valid_i),
    .asy_exec_done_i (asy_exec_done_i),
    .asy_req_o       (asy_req_o)
  );

  // ==========================================================
  // issue log: a start pulse may come while a bus task is busy
  always @(posedge clk_i) begin
    if (per_req_o.start === 1'b1) begin
      per_iss    <= per_iss + 1;
      per_iss_ix <= per_req_o.idx;
    end
    if (asy_req_o.start === 1'b1) begin
      asy_iss    <= asy_iss + 1;
      asy_iss_ix <= asy_req_o.idx;
    end
  end

  // ==========================================================
  // helpers; every task is entered just after a rising edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] ix,
                     input logic [15:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= {22'h000000, ix, 2'b00};
    sel_i <= 4'h3;
    dat_i <= {16'h0000, wd};
    // no latency assumed: wait for ack, bounded only against a hang
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50) chk({31'h0, ack_o}, 32'h0000_0001);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] ix, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, ix, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] ix, input logic [15:0] e);
    logic [31:0] r;
    bus(1'b0, ix, 16'h0000, r);
    chk(r, {16'h0000, e});
  endtask

  // waits for an issue on one list, then reports it finished
  task automatic serve(input logic asy, output logic [3:0] g);
    int n;
    n = 0;
    g = 4'h0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((asy ? asy_iss == asy_srv : per_iss == per_srv) && n < 200);
    if (n >= 200) begin
      chk(32'h0000_0000, 32'h0000_0001);
      return;
    end
    if (asy) begin
      g = asy_iss_ix;
      asy_srv++;
      asy_exec_done_i <= 1'b1;
    end else begin
      g = per_iss_ix;
      per_srv++;
      per_exec_done_i <= 1'b1;
    end
    @(posedge clk_i);
    asy_exec_done_i <= 1'b0;
    per_exec_done_i <= 1'b0;
  endtask

  // next descriptor the scan should issue after descriptor i
  function automatic int nxt(logic [15:0] sk, logic [15:0] mk, int i);
    int j;
    j = i;
    for (int n = 0; n < 32; n++) begin
      j = (mk[j] || j == 15) ? 0 : j + 1;
      if (!sk[j]) return j;
    end
    return -1;
  endfunction

  task automatic do_reset;
    rst_i       <= 1'b1;
    per_valid_i <= 16'h0000;
    asy_valid_i <= 16'h0000;
    repeat (2) @(posedge clk_i);
    // issues cut off by the reset are never served
    per_srv = per_iss;
    asy_srv = asy_iss;
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end

  // ==========================================================
  // tests
  initial begin
    logic [3:0]  a;
    logic [3:0]  b;
    logic [15:0] msk;
    logic [15:0] mk [3];
    mk = '{16'h0001, 16'h0002, 16'h0004};
    do_reset();
    rd_chk(DLM_IX_PER_DONE, DLM_RST_DONE);
    rd_chk(DLM_IX_ASY_DONE, DLM_RST_DONE);
    rd_chk(DLM_IX_PER_SKIP, DLM_RST_SKIP);
    rd_chk(DLM_IX_ASY_SKIP, DLM_RST_SKIP);
    rd_chk(DLM_IX_PER_LAST, DLM_RST_LAST);
    rd_chk(DLM_IX_ASY_LAST, DLM_RST_LAST);
    wr(8'hB6, 16'h5A5A);
    rd_chk(8'hB6, 16'h0000);
    wr(DLM_IX_PER_DONE, 16'hFFFF);
    rd_chk(DLM_IX_PER_DONE, 16'h0000);
    wr(DLM_IX_ASY_DONE, 16'hFFFF);
    rd_chk(DLM_IX_ASY_DONE, 16'h0000);
    $display("test reset_and_access done");

    // readback straight after the write exercises the minimum spacing
    wr(DLM_IX_PER_SKIP, 16'h1234);
    rd_chk(DLM_IX_PER_SKIP, 16'h1234);
    wr(DLM_IX_ASY_SKIP, 16'hEDCB);
    rd_chk(DLM_IX_ASY_SKIP, 16'hEDCB);
    wr(DLM_IX_PER_LAST, 16'hA5C3);
    rd_chk(DLM_IX_PER_LAST, 16'hA5C3);
    wr(DLM_IX_ASY_LAST, 16'h3C5A);
    rd_chk(DLM_IX_ASY_LAST, 16'h3C5A);
    $display("test read_write done");

    // periodic list: all valid, only 0 and 2 unskipped, scan ends at 2
    do_reset();
    per_valid_i <= 16'hFFFF;
    wr(DLM_IX_PER_LAST, 16'h0004);
    wr(DLM_IX_PER_SKIP, 16'hFFFA);
    serve(1'b0, a);
    rd_chk(DLM_IX_PER_DONE, 16'h0000);
    serve(1'b0, b);
    chk({28'h0, b}, 32'(nxt(16'hFFFA, 16'h0004, int'(a))));
    rd_chk(DLM_IX_PER_DONE, 16'h0001 << a);
    repeat (3) @(posedge clk_i);
    rd_chk(DLM_IX_PER_DONE, 16'h0001 << b);
    rd_chk(DLM_IX_PER_DONE, 16'h0000);
    rd_chk(DLM_IX_ASY_DONE, 16'h0000);
    $display("test periodic_scan done");

    // async list: each one-hot marker value bounds the scan
    for (int m = 0; m < 3; m++) begin
      do_reset();
      asy_valid_i <= 16'hFFFF;
      wr(DLM_IX_ASY_LAST, mk[m]);
      // let the scan wrap once so it sits inside the marked range
      repeat (20) @(posedge clk_i);
      wr(DLM_IX_ASY_SKIP, 16'h0000);
      serve(1'b1, a);
      msk = 16'h0001 << a;
      repeat (4) begin
        serve(1'b1, b);
        chk({28'h0, b}, 32'(nxt(16'h0000, mk[m], int'(a))));
        msk = msk | (16'h0001 << b);
        a = b;
      end
      repeat (3) @(posedge clk_i);
      rd_chk(DLM_IX_ASY_DONE, msk);
      rd_chk(DLM_IX_ASY_LAST, mk[m]);
    end
    $display("test async_marker done");
    end_sim();
  end

endmodule
